/* plirs_pkg.sv */
// Purpose: Constants shared by the interface reset and disable controller.
// Assumes: System clock of 125 MHz (8 ns period).
// Notes: Times are kept in their own unit; cycle counts derive from them.
package plirs_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Reset recognition window in picoseconds, 2.6 to 2.68 us.
  localparam int unsigned RESET_RECOG_MIN_PS = 2600000;
  localparam int unsigned RESET_RECOG_MAX_PS = 2680000;
  // Disable recognition, at most 26.11 us.
  localparam int unsigned DISABLE_RECOG_MAX_PS = 26110000;
  // Clock restart when not in low power, at most 60 ns.
  localparam int unsigned CLK_RESTART_FAST_PS = 60000;
  // Clock restart from low power, 5.3 to 7.3 ms, in nanoseconds.
  localparam longint unsigned CLK_RESTART_SLOW_MIN_NS = 64'd5300000;
  // Least time rounds up; longest times round down.
  localparam int unsigned RESET_CYC = (RESET_RECOG_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DISABLE_CYC = DISABLE_RECOG_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned FAST_RESTART_CYC = CLK_RESTART_FAST_PS / CLK_PERIOD_PS;
  localparam longint unsigned SLOW_RESTART_CYC_L =
    (CLK_RESTART_SLOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 13;
  localparam int unsigned WAKE_W = 20;
  localparam int unsigned PCLK_DIV_W = 2;
  localparam int unsigned INIT_W = 4;
  localparam logic [INIT_W-1:0] INIT_LOW_CYCLES = 4'h7;
  localparam logic [1:0] CTRL_IDLE = 2'h0;
  localparam logic [1:0] CTRL_RECEIVE = 2'h2;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] DATA_ON = 8'hff;
  typedef enum logic [2:0] {
    PLIRS_DISABLED, PLIRS_WAKE, PLIRS_INIT, PLIRS_RECV, PLIRS_NORMAL, PLIRS_RESET
  } plirs_state_type;
endpackage : plirs_pkg

/* plirs_ctrl.sv */
// Purpose: Interface reset, disable and initialisation control for the link-side port.
// Assumes: Power status arrives from another domain; interface clock is a divided output.
// Notes: Packet, status and request decoding live elsewhere and obey the gates given here.
// Functional notes
// - While not operational, cancel pending requests and ignore the request line.
// - Status made while not operational is dropped, never queued.
// - Reset the interface after 2.6 to 2.68 us of continuous deassertion.
// - Disable the interface no later than 26.11 us after deassertion began; the code disables 3265 cycles (26.12 us) after the first edge that samples it.
// - Restart interface clock on reassertion: 60 ns, or 5.3-7.3 ms from low power; the fast wake alone lasts 8 cycles (64 ns) here.
// - Entering reset ends bus activity, drives control and data low, ignores requests.
// - Disabled: outputs low as in reset, and interface clock held low.
// - Hardware reset places the interface directly in the disabled state.
// - Disabled with no active cable port: enter low-power state.
// - Reassertion from reset or disabled starts initialisation, then normal operation.
// - Initialisation: seven cycles low, eighth receive with all ones, then idle zero.
`timescale 1ns/1ps
module plirs_ctrl
  import plirs_pkg::*;
#(
  parameter longint unsigned SLOW_RESTART_CYC = SLOW_RESTART_CYC_L
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link side pins.
  input wire logic link_power_status,
  output logic interface_clock,
  output logic [1:0] interface_control_pair,
  output logic interface_control_oe,
  output logic [7:0] interface_data_lines,
  output logic interface_data_oe,
  // Core side.
  input wire logic any_port_active,
  input wire logic link_request_line,
  output logic request_accept,
  output logic status_enable,
  output logic cancel_pending,
  output logic low_power,
  output logic iface_operational
);
  logic lps_meta_reg, lps_sync_reg, lps_prev_reg;
  logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;
  logic [WAKE_W-1:0] wake_cnt_reg, wake_cnt_next;
  logic [PCLK_DIV_W-1:0] div_reg;
  logic [INIT_W-1:0] init_cnt_reg, init_cnt_next;
  plirs_state_type state_reg, state_next;
  logic lp_reg;
  logic pclk_reg, ctl_oe_reg, req_reg, stat_reg, cancel_reg, oper_reg;
  logic [1:0] ctl_reg;
  logic [7:0] dat_reg;

  // Two flops before any logic reads the status pin.
  always_ff @(posedge sys_clk) begin
    lps_meta_reg <= link_power_status;
    lps_sync_reg <= lps_meta_reg;
    lps_prev_reg <= lps_sync_reg;
  end

  // A low count that stops at the disable threshold so it cannot wrap.
  wire lps_high = lps_sync_reg;
  wire lps_rise = lps_sync_reg && !lps_prev_reg;
  wire reset_hit = (low_cnt_reg >= CNT_W'(RESET_CYC));
  wire disable_hit = (low_cnt_reg >= CNT_W'(DISABLE_CYC));
  wire pclk_tick = (div_reg == '0);
  wire pclk_rise = pclk_tick && !pclk_reg;
  wire [WAKE_W-1:0] wake_target = lp_reg ? WAKE_W'(SLOW_RESTART_CYC) : WAKE_W'(FAST_RESTART_CYC);
  wire wake_done = (wake_cnt_reg >= wake_target);
  wire clk_running = (state_reg != PLIRS_DISABLED) && (state_reg != PLIRS_WAKE);
  wire operational = (state_reg == PLIRS_NORMAL);

  always_comb begin
    low_cnt_next = low_cnt_reg;
    if (lps_high) begin
      low_cnt_next = '0;
    end else if (!disable_hit) begin
      low_cnt_next = low_cnt_reg + CNT_W'(1);
    end
  end

  always_comb begin
    state_next = state_reg;
    wake_cnt_next = wake_cnt_reg;
    init_cnt_next = init_cnt_reg;
    case (state_reg)
      PLIRS_NORMAL: begin
        if (reset_hit) begin
          state_next = PLIRS_RESET;
        end
      end
      PLIRS_RESET: begin
        if (disable_hit) begin
          state_next = PLIRS_DISABLED;
        end else if (lps_rise) begin
          state_next = PLIRS_INIT;
          init_cnt_next = '0;
        end
      end
      PLIRS_DISABLED: begin
        if (lps_rise) begin
          state_next = PLIRS_WAKE;
          wake_cnt_next = '0;
        end
      end
      PLIRS_WAKE: begin
        wake_cnt_next = wake_cnt_reg + WAKE_W'(1);
        if (wake_done) begin
          state_next = PLIRS_INIT;
          init_cnt_next = '0;
        end
      end
      PLIRS_INIT: begin
        if (reset_hit) begin
          state_next = PLIRS_RESET;
        end else if (pclk_rise) begin
          init_cnt_next = init_cnt_reg + INIT_W'(1);
          if (init_cnt_reg == INIT_LOW_CYCLES - INIT_W'(1)) begin
            state_next = PLIRS_RECV;
          end
        end
      end
      PLIRS_RECV: begin
        if (pclk_rise) begin
          state_next = PLIRS_NORMAL;
        end
      end
      default: begin
        state_next = PLIRS_DISABLED;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= PLIRS_DISABLED;
      low_cnt_reg <= '0;
      wake_cnt_reg <= '0;
      init_cnt_reg <= '0;
      div_reg <= '0;
      lp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      low_cnt_reg <= low_cnt_next;
      wake_cnt_reg <= wake_cnt_next;
      init_cnt_reg <= init_cnt_next;
      div_reg <= clk_running ? div_reg + PCLK_DIV_W'(1) : '0;
      // Once wake starts, low power is left only when the clock is back, so the wake delay is stable.
      lp_reg <= (state_reg == PLIRS_DISABLED) ? !any_port_active :
                (clk_running ? 1'b0 : lp_reg);
    end
  end

  // All pin and gate outputs are registered.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pclk_reg <= 1'b0;
      ctl_reg <= CTRL_IDLE;
      dat_reg <= DATA_ZERO;
      ctl_oe_reg <= 1'b1;
      req_reg <= 1'b0;
      stat_reg <= 1'b0;
      cancel_reg <= 1'b1;
      oper_reg <= 1'b0;
    end else begin
      if (!clk_running) begin
        pclk_reg <= 1'b0;
      end else if (pclk_tick) begin
        pclk_reg <= !pclk_reg;
      end
      ctl_reg <= (state_reg == PLIRS_RECV) ? CTRL_RECEIVE : CTRL_IDLE;
      dat_reg <= (state_reg == PLIRS_RECV) ? DATA_ON : DATA_ZERO;
      ctl_oe_reg <= 1'b1;
      req_reg <= operational && link_request_line;
      stat_reg <= operational;
      cancel_reg <= !operational;
      oper_reg <= operational;
    end
  end

  assign interface_clock = pclk_reg;
  assign interface_control_pair = ctl_reg;
  assign interface_control_oe = ctl_oe_reg;
  assign interface_data_lines = dat_reg;
  assign interface_data_oe = ctl_oe_reg;
  assign request_accept = req_reg;
  assign status_enable = stat_reg;
  assign cancel_pending = cancel_reg;
  assign low_power = lp_reg;
  assign iface_operational = oper_reg;

  chk_reset_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == PLIRS_NORMAL && reset_hit) |=> state_reg == PLIRS_RESET)
    else $error("Reset not entered after deassertion.");
  chk_disable_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == PLIRS_RESET && disable_hit) |=> state_reg == PLIRS_DISABLED)
    else $error("Disable not entered in time.");
  chk_clock_stopped: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == PLIRS_DISABLED) [*2] |-> !interface_clock)
    else $error("Interface clock runs while disabled.");
  chk_outputs_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $past(state_reg) == PLIRS_RESET |->
      interface_control_pair == CTRL_IDLE && interface_data_lines == DATA_ZERO)
    else $error("Outputs not low in reset.");
  chk_request_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    request_accept |-> iface_operational)
    else $error("Request accepted while not operational.");
  chk_status_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !iface_operational |-> !status_enable)
    else $error("Status enabled while not operational.");
  chk_counter_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lps_sync_reg |=> low_cnt_reg == '0)
    else $error("Deassertion counter not restarted.");
  chk_fast_wake: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == PLIRS_DISABLED && lps_rise && !lp_reg) |-> ##[1:9] state_reg == PLIRS_INIT)
    else $error("Clock restart too slow.");
  sequence init_low_seq;
    state_reg == PLIRS_INIT && init_cnt_reg == INIT_LOW_CYCLES - INIT_W'(1) && pclk_rise && !reset_hit;
  endsequence
  chk_init_receive: assert property (@(posedge sys_clk) disable iff (sys_rst)
    init_low_seq |=> ##1 interface_control_pair == CTRL_RECEIVE && interface_data_lines == DATA_ON)
    else $error("Receive with data-on not shown on eighth cycle.");
  chk_low_power: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_reg == PLIRS_DISABLED && !any_port_active) |=> low_power)
    else $error("Low power not entered.");
endmodule : plirs_ctrl

/* plirs_link_model.sv */
// Purpose: Behavioural link controller driving power status and requests.
// Assumes: Mode 0 deasserts, 1 asserts as a level, 2 asserts as pulses.
// Notes: Pulses are 48 ns high, 112 ns low, so a 30 percent duty cycle.
`timescale 1ns/1ps
module plirs_link_model (
  // Control from the bench.
  input wire logic [1:0] mode,
  input wire logic want_req,
  input wire logic misbehave,
  // Link pins.
  output logic link_power_status,
  output logic link_request_line
);
  logic pulse = 1'b0;
  initial begin
    forever begin
      pulse = 1'b1;
      #48;
      pulse = 1'b0;
      #112;
    end
  end
  assign link_power_status = (mode == 2'h1) | ((mode == 2'h2) & pulse);
  // Only a rogue link keeps requesting once power status has dropped.
  assign link_request_line = want_req & ((mode != 2'h0) | misbehave);
endmodule : plirs_link_model

/* test_phy_link_iface_reset_disable.sv */
// Purpose: Self-checking bench for the interface reset and disable controller.
// Assumes: Slow clock restart shortened to 50 cycles.
// Notes: Windows are counted in sys_clk cycles of 8 ns.
`timescale 1ns/1ps
module test_phy_link_iface_reset_disable;
  import plirs_pkg::*;
  `define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
  int n_mismatch = 0;
  int total_checks = 0;
  int rise_cnt = 0;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic want_req = 1'b0;
  logic misbehave = 1'b0;
  logic any_port_active = 1'b0;
  logic link_power_status, link_request_line, interface_clock, interface_control_oe;
  logic interface_data_oe, request_accept, status_enable, cancel_pending, low_power;
  logic iface_operational;
  logic [1:0] interface_control_pair;
  logic [7:0] interface_data_lines;
  plirs_link_model link (.mode(mode), .want_req(want_req), .misbehave(misbehave),
    .link_power_status(link_power_status), .link_request_line(link_request_line));
  plirs_ctrl #(.SLOW_RESTART_CYC(50)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link_power_status(link_power_status), .interface_clock(interface_clock),
    .interface_control_pair(interface_control_pair), .interface_control_oe(interface_control_oe),
    .interface_data_lines(interface_data_lines), .interface_data_oe(interface_data_oe),
    .any_port_active(any_port_active), .link_request_line(link_request_line),
    .request_accept(request_accept), .status_enable(status_enable),
    .cancel_pending(cancel_pending), .low_power(low_power), .iface_operational(iface_operational));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge interface_clock) rise_cnt++;
  task automatic wait_init(output int first);
    int n;
    first = 0;
    // Let the pin pass the synchroniser so rises made before initialisation are not counted.
    repeat (3) @(posedge sys_clk);
    #1;
    rise_cnt = 0;
    for (n = 0; n < 400 && interface_control_pair !== CTRL_RECEIVE; n++) begin
      @(posedge sys_clk);
      #1;
      if (rise_cnt == 0) first = n + 1;
    end
    `CHK("init clocks", 7, rise_cnt)
    `CHK("init data", DATA_ON, interface_data_lines)
    for (n = 0; n < 20 && interface_control_pair !== CTRL_IDLE; n++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("idle data", DATA_ZERO, interface_data_lines)
    `CHK("operational", 1'b1, iface_operational)
    `CHK("status on", 1'b1, status_enable)
  endtask : wait_init
  task automatic s_hw_reset;
    int t;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("clock off", 1'b0, interface_clock)
    `CHK("ctl off", CTRL_IDLE, interface_control_pair)
    `CHK("cancel", 1'b1, cancel_pending)
    `CHK("ctl drive", 1'b1, interface_control_oe)
    `CHK("data drive", 1'b1, interface_data_oe)
    `CHK("low power", 1'b1, low_power)
    @(posedge sys_clk);
    mode <= 2'h1;
    wait_init(t);
    `CHK("slow wake", 1'b1, t > 50)
  endtask : s_hw_reset
  task automatic s_short_reset;
    int n;
    int t;
    @(posedge sys_clk);
    want_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("accept", 1'b1, request_accept)
    @(posedge sys_clk);
    mode <= 2'h0;
    misbehave <= 1'b1;
    for (n = 0; n < 400 && cancel_pending !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK("reset time", 1'b1, n >= 325 && n <= 335)
    rise_cnt = 0;
    repeat (250) @(posedge sys_clk);
    #1;
    `CHK("reject", 1'b0, request_accept)
    `CHK("status off", 1'b0, status_enable)
    `CHK("data reset", DATA_ZERO, interface_data_lines)
    `CHK("clock runs", 1'b1, rise_cnt > 8)
    @(posedge sys_clk);
    misbehave <= 1'b0;
    want_req <= 1'b0;
    mode <= 2'h1;
    wait_init(t);
  endtask : s_short_reset
  task automatic s_disable;
    int t;
    @(posedge sys_clk);
    any_port_active <= 1'b1;
    mode <= 2'h0;
    repeat (3270) @(posedge sys_clk);
    rise_cnt = 0;
    repeat (40) @(posedge sys_clk);
    #1;
    `CHK("clock stopped", 0, rise_cnt)
    `CHK("awake", 1'b0, low_power)
    @(posedge sys_clk);
    mode <= 2'h1;
    wait_init(t);
    `CHK("fast wake", 1'b1, t <= 16)
  endtask : s_disable
  task automatic s_pulsed;
    int n;
    int bad;
    bad = 0;
    @(posedge sys_clk);
    mode <= 2'h2;
    for (n = 0; n < 2000; n++) begin
      @(posedge sys_clk);
      #1;
      if (iface_operational !== 1'b1) bad++;
    end
    `CHK("pulsed hold", 0, bad)
  endtask : s_pulsed
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #160000;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    s_hw_reset();
    s_short_reset();
    s_disable();
    s_pulsed();
    close_out();
  end
endmodule : test_phy_link_iface_reset_disable
